// [inc/spsel_map.svh]
// Purpose: register map, field positions, reset values and source codes of the status pin selector
// Assumes: 8-bit registers reached through the device's own register port
// Notes: shared by the package user files through a plain include
// Functional notes
// - codes 1000,1001,1010 drive update, invalid, zero
// - codes 1011,1100,1101 drive compressed, copy-permit, emphasis
// - code 1110 makes pin five a logic-level input
// - code 1111 makes pin five a comparator input
// - pin nine field bits 3:0, reset 1000
// - masked loss-of-lock update raises no interrupt
// - masked receive-fault update raises no interrupt
// - masked status-update flag raises no interrupt
// - compressed, copy, emphasis flags each maskable
// - masked incoming-rate update raises no interrupt
`ifndef SPSEL_MAP_SVH
`define SPSEL_MAP_SVH

// register offsets
`define SPSEL_ADDR_SELECT_A 8'h28
`define SPSEL_ADDR_SELECT_B 8'h29
`define SPSEL_ADDR_SELECT_C 8'h2a
`define SPSEL_ADDR_MASK 8'h2b
`define SPSEL_ADDR_FLAGS 8'h2c

// reset values
`define SPSEL_RST_SELECT_A 8'h54
`define SPSEL_RST_SELECT_B 8'h76
`define SPSEL_RST_SELECT_C 8'h98
`define SPSEL_RST_MASK 8'h00

// field positions of a selector register
`define SPSEL_LO_FIELD 3:0
`define SPSEL_HI_FIELD 7:4

// mask bit positions
`define SPSEL_MB_UNLOCK 0
`define SPSEL_MB_INVALID 1
`define SPSEL_MB_CHANNEL_STATUS_UPDATE 2
`define SPSEL_MB_FAULT 3
`define SPSEL_MB_COMPRESSED 4
`define SPSEL_MB_COPY 5
`define SPSEL_MB_EMPHASIS 6
`define SPSEL_MB_RATE 7

// source codes
`define SPSEL_CODE_CHANNEL_STATUS_UPDATE 4'h8
`define SPSEL_CODE_INVALID 4'h9
`define SPSEL_CODE_ZERO 4'ha
`define SPSEL_CODE_COMPRESSED 4'hb
`define SPSEL_CODE_COPY 4'hc
`define SPSEL_CODE_EMPHASIS 4'hd
`define SPSEL_CODE_IN_CMOS 4'he
`define SPSEL_CODE_IN_CMP 4'hf

// pins with receiver-input option (pin five is index 0)
`define SPSEL_INPUT_CAPABLE 6'h01

`endif

// [inc/spsel_pkg.sv]
// Purpose: types of the status pin selector
// Assumes: constants come from spsel_map.svh
// Notes: flags arrive from receiver logic on clk_sys
package spsel_pkg;

  // pin role chosen by a source code
  typedef enum logic [1:0] {
    SPSEL_MODE_OFF = 2'b00,
    SPSEL_MODE_OUT = 2'b01,
    SPSEL_MODE_IN_CMOS = 2'b10,
    SPSEL_MODE_IN_CMP = 2'b11
  } spsel_mode_t;

  // receiver status flags
  typedef struct packed {
    logic [1:0] incoming_rate_field;
    logic emphasis_flag;
    logic copy_permit_flag;
    logic compressed_payload_flag;
    logic receive_fault_flag;
    logic channel_status_update;
    logic invalid_flag;
    logic zero_sample_flag;
    logic loss_of_lock;
  } spsel_flags_t;

  // register write request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spsel_reg_req_t;

endpackage

// [core/spsel_pin_mux.sv]
// Purpose: one general output pin, source select and role
// Assumes: flags synchronous to clk_sys
// Notes: outputs registered, one cycle after code or flag
`timescale 1ns/1ps
`include "spsel_map.svh"
module spsel_pin_mux #(
  parameter bit INPUT_OK = 1'b0 // pin may become receiver input
) (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, low
  input wire logic [3:0] code, // source code
  input wire spsel_pkg::spsel_flags_t flags, // receiver flags
  output logic pin_out, // pin level
  output logic pin_oe, // pin driven
  output spsel_pkg::spsel_mode_t mode // pin role
);
  logic next_out;
  logic next_oe;
  spsel_pkg::spsel_mode_t next_mode;

  // decode source code
  always_comb begin
    next_out = 1'b0;
    next_oe = 1'b1;
    next_mode = spsel_pkg::SPSEL_MODE_OUT;
    case (code)
      `SPSEL_CODE_CHANNEL_STATUS_UPDATE: next_out = flags.channel_status_update;
      `SPSEL_CODE_INVALID: next_out = flags.invalid_flag;
      `SPSEL_CODE_ZERO: next_out = flags.zero_sample_flag;
      `SPSEL_CODE_COMPRESSED: next_out = flags.compressed_payload_flag;
      `SPSEL_CODE_COPY: next_out = flags.copy_permit_flag;
      `SPSEL_CODE_EMPHASIS: next_out = flags.emphasis_flag;
      `SPSEL_CODE_IN_CMOS: begin
        next_oe = 1'b0;
        next_mode = INPUT_OK ? spsel_pkg::SPSEL_MODE_IN_CMOS : spsel_pkg::SPSEL_MODE_OFF;
      end
      `SPSEL_CODE_IN_CMP: begin
        next_oe = 1'b0;
        next_mode = INPUT_OK ? spsel_pkg::SPSEL_MODE_IN_CMP : spsel_pkg::SPSEL_MODE_OFF;
      end
      default: begin
        next_oe = 1'b0;
        next_mode = spsel_pkg::SPSEL_MODE_OFF;
      end
    endcase
  end

  // pin registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      mode <= spsel_pkg::SPSEL_MODE_OFF;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      mode <= next_mode;
    end
  end
endmodule

// [core/spsel_top.sv]
// Purpose: status pin selector, pins five to ten, interrupt masking
// Assumes: register port driven by the control interface on clk_sys
// Notes: pin inputs pass three flops to the receiver outputs; interrupt is a one-cycle low pulse
`timescale 1ns/1ps
`include "spsel_map.svh"
module spsel_top #(
  parameter int NUM_PINS = 6 // pins five to ten
) (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, low
  input wire spsel_pkg::spsel_reg_req_t reg_req, // register write request
  output logic [7:0] reg_rdata, // read data, one cycle late
  input wire spsel_pkg::spsel_flags_t flags, // receiver flags
  input wire logic [NUM_PINS-1:0] general_output_pin_in, // pin levels
  output logic [NUM_PINS-1:0] general_output_pin_out, // pin drive values
  output logic [NUM_PINS-1:0] general_output_pin_oe, // pin drive enables
  output logic rx_serial_data, // receiver input from a pin
  output logic rx_serial_valid, // some pin is a receiver input
  output logic rx_use_comparator, // that pin uses comparator
  output logic int_n // interrupt, low pulse
);
  localparam int NFLAG = $bits(spsel_pkg::spsel_flags_t);

  logic [7:0] select_a;
  logic [7:0] status_pin_select_b;
  logic [7:0] status_pin_select_c;
  logic [7:0] irq_mask;
  logic [3:0] code [NUM_PINS];
  spsel_pkg::spsel_mode_t mode [NUM_PINS];
  spsel_pkg::spsel_flags_t prev_flags;
  logic [NFLAG-1:0] flag_change;
  logic [7:0] upd;
  logic [NUM_PINS-1:0] sync1;
  logic [NUM_PINS-1:0] sync2;
  logic next_rx_data;
  logic next_rx_valid;
  logic next_rx_cmp;

  // one mask bit per interrupt source
  function automatic logic [7:0] source_updates(input spsel_pkg::spsel_flags_t ch);
    logic [7:0] u;
    u = 8'h00;
    u[`SPSEL_MB_UNLOCK] = ch.loss_of_lock;
    u[`SPSEL_MB_INVALID] = ch.invalid_flag;
    u[`SPSEL_MB_CHANNEL_STATUS_UPDATE] = ch.channel_status_update;
    u[`SPSEL_MB_FAULT] = ch.receive_fault_flag;
    u[`SPSEL_MB_COMPRESSED] = ch.compressed_payload_flag;
    u[`SPSEL_MB_COPY] = ch.copy_permit_flag;
    u[`SPSEL_MB_EMPHASIS] = ch.emphasis_flag;
    u[`SPSEL_MB_RATE] = |ch.incoming_rate_field;
    return u;
  endfunction

  // selector register a: pins five and six
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      select_a <= `SPSEL_RST_SELECT_A;
    end else if (reg_req.wr && reg_req.addr == `SPSEL_ADDR_SELECT_A) begin
      select_a <= reg_req.wdata;
    end
  end

  // selector register b: pins seven and eight
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      status_pin_select_b <= `SPSEL_RST_SELECT_B;
    end else if (reg_req.wr && reg_req.addr == `SPSEL_ADDR_SELECT_B) begin
      status_pin_select_b <= reg_req.wdata;
    end
  end

  // selector register c: pins nine and ten
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      status_pin_select_c <= `SPSEL_RST_SELECT_C;
    end else if (reg_req.wr && reg_req.addr == `SPSEL_ADDR_SELECT_C) begin
      status_pin_select_c <= reg_req.wdata;
    end
  end

  // interrupt mask register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= `SPSEL_RST_MASK;
    end else if (reg_req.wr && reg_req.addr == `SPSEL_ADDR_MASK) begin
      irq_mask <= reg_req.wdata;
    end
  end

  // read mux, unmapped reads zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.addr == `SPSEL_ADDR_SELECT_A) begin
      reg_rdata <= select_a;
    end else if (reg_req.addr == `SPSEL_ADDR_SELECT_B) begin
      reg_rdata <= status_pin_select_b;
    end else if (reg_req.addr == `SPSEL_ADDR_SELECT_C) begin
      reg_rdata <= status_pin_select_c;
    end else if (reg_req.addr == `SPSEL_ADDR_MASK) begin
      reg_rdata <= irq_mask;
    end else if (reg_req.addr == `SPSEL_ADDR_FLAGS) begin
      reg_rdata <= prev_flags[7:0];
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // per-pin codes
  assign code[0] = select_a[`SPSEL_LO_FIELD];
  assign code[1] = select_a[`SPSEL_HI_FIELD];
  assign code[2] = status_pin_select_b[`SPSEL_LO_FIELD]; // pin_seven_source_code
  assign code[3] = status_pin_select_b[`SPSEL_HI_FIELD]; // pin_eight_source_code
  assign code[4] = status_pin_select_c[`SPSEL_LO_FIELD]; // pin_nine_source_code
  assign code[5] = status_pin_select_c[`SPSEL_HI_FIELD];

  // one selector per pin
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    spsel_pin_mux #(
      .INPUT_OK(1'((`SPSEL_INPUT_CAPABLE >> i) & 6'h01))
    ) u_mux (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .code(code[i]),
      .flags(flags),
      .pin_out(general_output_pin_out[i]),
      .pin_oe(general_output_pin_oe[i]),
      .mode(mode[i])
    );
  end

  // two-flop synchroniser on pin levels
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= general_output_pin_in;
      sync2 <= sync1;
    end
  end

  // lowest input-mode pin feeds the receiver
  always_comb begin
    next_rx_data = 1'b0;
    next_rx_valid = 1'b0;
    next_rx_cmp = 1'b0;
    for (int i = NUM_PINS - 1; i >= 0; i--) begin
      if (mode[i] == spsel_pkg::SPSEL_MODE_IN_CMOS || mode[i] == spsel_pkg::SPSEL_MODE_IN_CMP) begin
        next_rx_data = sync2[i];
        next_rx_valid = 1'b1;
        next_rx_cmp = (mode[i] == spsel_pkg::SPSEL_MODE_IN_CMP);
      end
    end
  end

  // receiver input registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_serial_data <= 1'b0;
      rx_serial_valid <= 1'b0;
      rx_use_comparator <= 1'b0;
    end else begin
      rx_serial_data <= next_rx_data;
      rx_serial_valid <= next_rx_valid;
      rx_use_comparator <= next_rx_cmp;
    end
  end

  // flag change detect
  assign flag_change = flags ^ prev_flags;
  assign upd = source_updates(flag_change);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev_flags <= '0;
    end else begin
      prev_flags <= flags;
    end
  end

  // interrupt pulse on unmasked update
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~|(upd & ~irq_mask);
    end
  end

  // helper: selector c never written since reset
  logic c_written;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      c_written <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == `SPSEL_ADDR_SELECT_C) begin
      c_written <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_code7(logic [3:0] c);
    code[2] == c;
  endsequence

  property p_channel_status_update_route;
    s_code7(`SPSEL_CODE_CHANNEL_STATUS_UPDATE) |=> general_output_pin_oe[2] &&
      general_output_pin_out[2] == $past(flags.channel_status_update);
  endproperty
  a_channel_status_update_route: assert property (p_channel_status_update_route) else $error("pin seven not showing update flag");

  property p_zero_route;
    code[4] == `SPSEL_CODE_ZERO |=> general_output_pin_oe[4] &&
      general_output_pin_out[4] == $past(flags.zero_sample_flag);
  endproperty
  a_zero_route: assert property (p_zero_route) else $error("pin nine not showing zero flag");

  property p_invalid_route;
    code[5] == `SPSEL_CODE_INVALID |=> general_output_pin_oe[5] &&
      general_output_pin_out[5] == $past(flags.invalid_flag);
  endproperty
  a_invalid_route: assert property (p_invalid_route) else $error("pin ten lost invalid flag");

  property p_compressed_route;
    code[4] == `SPSEL_CODE_COMPRESSED |=> general_output_pin_oe[4] &&
      general_output_pin_out[4] == $past(flags.compressed_payload_flag);
  endproperty
  a_compressed_route: assert property (p_compressed_route) else $error("pin nine lost compressed flag");

  property p_emphasis_route;
    code[3] == `SPSEL_CODE_EMPHASIS |=> general_output_pin_oe[3] &&
      general_output_pin_out[3] == $past(flags.emphasis_flag);
  endproperty
  a_emphasis_route: assert property (p_emphasis_route) else $error("pin eight lost emphasis flag");

  property p_low_code_off;
    code[4] < `SPSEL_CODE_CHANNEL_STATUS_UPDATE |=> !general_output_pin_oe[4] && !general_output_pin_out[4];
  endproperty
  a_low_code_off: assert property (p_low_code_off) else $error("pin nine driven on low code");

  property p_copy_route;
    s_code7(`SPSEL_CODE_COPY) |=> general_output_pin_out[2] == $past(flags.copy_permit_flag);
  endproperty
  a_copy_route: assert property (p_copy_route) else $error("pin seven not showing copy flag");

  property p_cmos_input;
    code[0] == `SPSEL_CODE_IN_CMOS |=> !general_output_pin_oe[0] ##1 rx_serial_valid && !rx_use_comparator;
  endproperty
  a_cmos_input: assert property (p_cmos_input) else $error("pin five not a logic-level input");

  property p_no_input_on_seven;
    code[2] == `SPSEL_CODE_IN_CMP && code[0] != `SPSEL_CODE_IN_CMOS && code[0] != `SPSEL_CODE_IN_CMP
      |=> !general_output_pin_oe[2] ##1 !rx_serial_valid;
  endproperty
  a_no_input_on_seven: assert property (p_no_input_on_seven) else $error("pin seven became an input");

  property p_cmp_input;
    code[0] == `SPSEL_CODE_IN_CMP |=> ##1 rx_use_comparator && rx_serial_valid;
  endproperty
  a_cmp_input: assert property (p_cmp_input) else $error("pin five not a comparator input");

  property p_pin_nine_reset;
    !c_written |-> code[4] == `SPSEL_CODE_CHANNEL_STATUS_UPDATE;
  endproperty
  a_pin_nine_reset: assert property (p_pin_nine_reset) else $error("pin nine code lost its reset value");

  property p_mask_unlock;
    irq_mask[`SPSEL_MB_UNLOCK] && upd == 8'h01 |=> int_n;
  endproperty
  a_mask_unlock: assert property (p_mask_unlock) else $error("masked lock loss raised interrupt");

  property p_mask_fault;
    irq_mask[`SPSEL_MB_FAULT] && upd == 8'h08 |=> int_n;
  endproperty
  a_mask_fault: assert property (p_mask_fault) else $error("masked fault raised interrupt");

  property p_mask_channel_status_update;
    irq_mask[`SPSEL_MB_CHANNEL_STATUS_UPDATE] && upd == 8'h04 |=> int_n;
  endproperty
  a_mask_channel_status_update: assert property (p_mask_channel_status_update) else $error("masked update flag raised interrupt");

  property p_mask_copy;
    irq_mask[`SPSEL_MB_COPY] && upd == 8'h20 |=> int_n;
  endproperty
  a_mask_copy: assert property (p_mask_copy) else $error("masked copy flag raised interrupt");

  property p_mask_compressed;
    irq_mask[`SPSEL_MB_COMPRESSED] && upd == 8'h10 |=> int_n;
  endproperty
  a_mask_compressed: assert property (p_mask_compressed) else $error("masked compressed gave interrupt");

  property p_mask_emphasis;
    irq_mask[`SPSEL_MB_EMPHASIS] && upd == 8'h40 |=> int_n;
  endproperty
  a_mask_emphasis: assert property (p_mask_emphasis) else $error("masked emphasis gave interrupt");

  property p_mask_rate;
    irq_mask[`SPSEL_MB_RATE] && upd == 8'h80 |=> int_n;
  endproperty
  a_mask_rate: assert property (p_mask_rate) else $error("masked rate update raised interrupt");

  property p_unmasked_irq;
    $changed(flags.receive_fault_flag) && !irq_mask[`SPSEL_MB_FAULT] |=> !int_n;
  endproperty
  a_unmasked_irq: assert property (p_unmasked_irq) else $error("unmasked fault gave no interrupt");

endmodule

// [verif/spsel_ctrl_model.sv]
// Purpose: external controller on the status pins, resolves each pin level
// Assumes: device drive wins whenever its enable is high
// Notes: released pins show a pattern that flips every cycle, pin five carries serial data
`timescale 1ns/1ps
module spsel_ctrl_model (
  input wire logic clk_sys, // system clock
  input wire logic [5:0] pin_out, // device drive values
  input wire logic [5:0] pin_oe, // device drive enables
  input wire logic serial_bit, // bit sent towards pin five
  output logic [5:0] pin_level // resolved pin levels
);
  logic [5:0] idle_pat = 6'h2a;

  // released pins never hold a stale level
  always @(posedge clk_sys) begin
    idle_pat <= ~idle_pat;
  end

  // wire level from the device enables, controller drives the rest
  always_comb begin
    pin_level = idle_pat;
    pin_level[0] = serial_bit;
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end
    end
  end
endmodule

// [verif/tb_status_pin_selector.sv]
// Purpose: self-checking bench of the status pin selector
// Assumes: inputs change 1 ns after the rising edge
// Notes: random flags and codes from a fixed seed, corner codes walked in full
`timescale 1ns/1ps
`include "spsel_map.svh"
module tb_status_pin_selector;
  logic clk_sys;
  logic rstn;
  spsel_pkg::spsel_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  spsel_pkg::spsel_flags_t flags;
  logic [5:0] pin_in;
  logic [5:0] pin_out;
  logic [5:0] pin_oe;
  logic rx_data;
  logic rx_valid;
  logic rx_cmp;
  logic int_n;
  logic serial_bit;
  int err_total;
  int cmp_count;
  int seed;
  int src_map[8] = '{0, 2, 3, 4, 5, 6, 7, 8};

  spsel_top i_spsel_top (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .flags(flags),
    .general_output_pin_in(pin_in),
    .general_output_pin_out(pin_out),
    .general_output_pin_oe(pin_oe),
    .rx_serial_data(rx_data),
    .rx_serial_valid(rx_valid),
    .rx_use_comparator(rx_cmp),
    .int_n(int_n)
  );

  spsel_ctrl_model i_spsel_ctrl_model (
    .clk_sys(clk_sys),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .serial_bit(serial_bit),
    .pin_level(pin_in)
  );

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // verdict and end of run
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // byte results
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single-bit results
  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // n edges, then settle past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // register write, strobe one cycle, one idle cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    step(1);
    reg_req.wr = 1'b0;
    step(1);
  endtask

  // register read, data one cycle after address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_req.addr = a;
    step(1);
    chk_byte(what, exp, reg_rdata);
  endtask

  // expected pin level for a source code
  function automatic logic exp_pin(input logic [3:0] c, input spsel_pkg::spsel_flags_t f);
    case (c)
      4'h8: return f.channel_status_update;
      4'h9: return f.invalid_flag;
      4'ha: return f.zero_sample_flag;
      4'hb: return f.compressed_payload_flag;
      4'hc: return f.copy_permit_flag;
      4'hd: return f.emphasis_flag;
      default: return 1'b0;
    endcase
  endfunction

  // hang guard
  initial begin
    #100000;
    err_total++;
    end_sim();
  end

  // main sequence
  initial begin
    logic [3:0] c;
    int b;
    seed = 67;
    err_total = 0;
    cmp_count = 0;
    rstn = 1'b0;
    reg_req = '0;
    flags = '0;
    serial_bit = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    rd(`SPSEL_ADDR_SELECT_A, `SPSEL_RST_SELECT_A, "select a reset");
    rd(`SPSEL_ADDR_SELECT_B, `SPSEL_RST_SELECT_B, "select b reset");
    rd(`SPSEL_ADDR_SELECT_C, `SPSEL_RST_SELECT_C, "select c reset");
    rd(`SPSEL_ADDR_MASK, `SPSEL_RST_MASK, "mask reset");
    rd(8'h3c, 8'h00, "unmapped read");
    chk_byte("reset pin enables", 8'h30, {2'b00, pin_oe});
    // every code on pins seven and nine, then random codes; eight on emphasis, ten on invalid
    for (int i = 0; i < 40; i++) begin
      c = (i < 16) ? i[3:0] : 4'($random(seed));
      wr(`SPSEL_ADDR_SELECT_C, {`SPSEL_CODE_INVALID, c});
      wr(`SPSEL_ADDR_SELECT_B, {`SPSEL_CODE_EMPHASIS, c});
      for (int k = 0; k < 3; k++) begin
        flags = spsel_pkg::spsel_flags_t'(10'($random(seed)));
        step(2);
        chk_bit("pin nine level", exp_pin(c, flags), pin_out[4]);
        chk_bit("pin nine enable", c inside {[4'h8:4'hd]}, pin_oe[4]);
        chk_bit("pin ten level", flags.invalid_flag, pin_out[5]);
        chk_bit("pin seven level", exp_pin(c, flags), pin_out[2]);
        chk_bit("pin seven enable", c inside {[4'h8:4'hd]}, pin_oe[2]);
        chk_bit("pin eight level", flags.emphasis_flag, pin_out[3]);
        chk_bit("no rx from pins seven nine", 1'b0, rx_valid);
      end
    end
    rd(`SPSEL_ADDR_SELECT_C, {`SPSEL_CODE_INVALID, c}, "select c readback");
    rd(`SPSEL_ADDR_SELECT_B, {`SPSEL_CODE_EMPHASIS, c}, "select b readback");
    // pin five as receiver input, buffer then comparator
    for (int k = 0; k < 2; k++) begin
      wr(`SPSEL_ADDR_SELECT_A, {4'h5, k[0] ? `SPSEL_CODE_IN_CMP : `SPSEL_CODE_IN_CMOS});
      step(2);
      chk_bit("rx valid", 1'b1, rx_valid);
      chk_bit("rx comparator", k[0], rx_cmp);
      chk_bit("pin five enable", 1'b0, pin_oe[0]);
      repeat (6) begin
        serial_bit = 1'($random(seed));
        step(4);
        chk_bit("rx data", serial_bit, rx_data);
      end
    end
    wr(`SPSEL_ADDR_SELECT_A, `SPSEL_RST_SELECT_A);
    step(2);
    chk_bit("rx released", 1'b0, rx_valid);
    // each source unmasked with all others masked, then masked alone
    for (int s = 0; s < 8; s++) begin
      for (int m = 0; m < 2; m++) begin
        wr(`SPSEL_ADDR_MASK, m[0] ? (8'h01 << s) : ~(8'h01 << s));
        step(1);
        b = src_map[s] + ((s == 7) ? ($random(seed) & 1) : 0);
        flags[b] = ~flags[b];
        step(1);
        chk_bit("int pulse", m[0], int_n);
        step(1);
        chk_bit("int release", 1'b1, int_n);
      end
    end
    rd(`SPSEL_ADDR_MASK, 8'h80, "mask readback");
    // zero flag is not an interrupt source
    wr(`SPSEL_ADDR_MASK, 8'h00);
    flags.zero_sample_flag = ~flags.zero_sample_flag;
    step(1);
    chk_bit("zero flag no int", 1'b1, int_n);
    // snapshot register is read-only
    wr(`SPSEL_ADDR_FLAGS, ~flags[7:0]);
    rd(`SPSEL_ADDR_FLAGS, flags[7:0], "flag snapshot");
    end_sim();
  end
endmodule
